/* File: rtl/afd_defines.svh */
// constants for the alpha field decoder
`ifndef AFD_DEFINES_SVH
`define AFD_DEFINES_SVH
`define AFD_TAG_RAW    8'h80
`define AFD_TAG_HALF8  8'h81
`define AFD_TAG_FULL16 8'h82
`define AFD_PAD_BYTE   8'hff
`define AFD_PAD_WORD   16'hffff
`define AFD_HDR_HALF8  3'h3
`define AFD_HDR_FULL16 3'h4
`define AFD_TOP_BIT    7
`endif

/* File: rtl/afd_pkg.sv */
// types for the alpha field decoder
package afd_pkg;
  typedef enum logic [2:0] {
    AFD_IDLE, AFD_FORM, AFD_COUNT, AFD_BASE_HI, AFD_BASE_LO, AFD_BODY, AFD_DROP
  } afd_state_t;
  typedef enum logic [1:0] {AFD_PLAIN, AFD_RAW, AFD_HALF, AFD_FULL} afd_form_t;
endpackage

/* File: rtl/afd_char_map.sv */
// maps one body byte of a base-pointer record to a code point
`timescale 1ns/1ps
`include "afd_defines.svh"
module afd_char_map (
  input  wire logic [7:0]  byte_i,
  input  wire logic [15:0] base_i,
  output logic      [15:0] code_o
);
  always_comb begin
    if (byte_i[`AFD_TOP_BIT]) begin
      code_o = base_i + {9'h000, byte_i[6:0]};
    end else begin
      code_o = {9'h000, byte_i[6:0]};
    end
  end
endmodule // afd_char_map

/* File: rtl/afd_decoder.sv */
// alpha field decoder: record bytes in, 16-bit code points out
`timescale 1ns/1ps
`include "afd_defines.svh"
module afd_decoder (
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  in_data_i,
  input  wire logic        in_valid_i,
  input  wire logic        in_last_i,
  output logic             in_ready_o,
  output logic [15:0]      out_char_o,
  output logic             out_valid_o,
  output logic             out_end_o,
  input  wire logic        out_ready_i,
  output logic [1:0]       form_o
);
  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    afd_pkg::afd_state_t st;
    afd_pkg::afd_form_t  form;
    logic [7:0]          count;
    logic [15:0]         base;
    logic [7:0]          hi;
    logic                have_hi;
    logic [15:0]         chr;
    logic                vld;
    logic                fin;
  } afd_regs_t;

  afd_regs_t r_ff;
  afd_regs_t nxt_r;
  logic [15:0] map_code;
  logic        take;
  logic        slot_free;

  afd_char_map u_map (
    .byte_i (in_data_i),
    .base_i (r_ff.base),
    .code_o (map_code)
  );

  // output register empties on accept; input stalls while it is full and out_ready_i is low
  assign slot_free  = !r_ff.vld || out_ready_i;
  assign in_ready_o = slot_free;
  assign take       = in_valid_i && slot_free;

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    nxt_r = r_ff;
    if (r_ff.vld && out_ready_i) begin
      nxt_r.vld = 1'b0;
      nxt_r.fin = 1'b0;
    end
    if (take) begin
      unique case (r_ff.st)
        afd_pkg::AFD_IDLE, afd_pkg::AFD_FORM: begin
          nxt_r.have_hi = 1'b0;
          unique case (in_data_i)
            `AFD_TAG_RAW: begin
              nxt_r.form = afd_pkg::AFD_RAW;
              nxt_r.st   = afd_pkg::AFD_BODY;
            end
            `AFD_TAG_HALF8: begin
              nxt_r.form = afd_pkg::AFD_HALF;
              nxt_r.st   = afd_pkg::AFD_COUNT;
            end
            `AFD_TAG_FULL16: begin
              nxt_r.form = afd_pkg::AFD_FULL;
              nxt_r.st   = afd_pkg::AFD_COUNT;
            end
            default: begin
              // plain record: first byte is already a character
              nxt_r.form = afd_pkg::AFD_PLAIN;
              nxt_r.st   = afd_pkg::AFD_BODY;
              nxt_r.chr  = {9'h000, in_data_i[6:0]};
              nxt_r.vld  = 1'b1;
            end
          endcase
        end
        afd_pkg::AFD_COUNT: begin
          nxt_r.count = in_data_i;
          nxt_r.st    = afd_pkg::AFD_BASE_HI;
        end
        afd_pkg::AFD_BASE_HI: begin
          if (r_ff.form == afd_pkg::AFD_HALF) begin
            nxt_r.base = {1'b0, in_data_i, 7'h00};
            nxt_r.st   = afd_pkg::AFD_BODY;
          end else begin
            nxt_r.base = {in_data_i, 8'h00};
            nxt_r.st   = afd_pkg::AFD_BASE_LO;
          end
        end
        afd_pkg::AFD_BASE_LO: begin
          nxt_r.base = {r_ff.base[15:8], in_data_i};
          nxt_r.st   = afd_pkg::AFD_BODY;
        end
        afd_pkg::AFD_BODY: begin
          unique case (r_ff.form)
            afd_pkg::AFD_RAW: begin
              if (!r_ff.have_hi) begin
                nxt_r.hi      = in_data_i;
                nxt_r.have_hi = 1'b1;
              end else begin
                nxt_r.have_hi = 1'b0;
                if ({r_ff.hi, in_data_i} == `AFD_PAD_WORD) begin
                  nxt_r.st = afd_pkg::AFD_DROP;
                end else begin
                  nxt_r.chr = {r_ff.hi, in_data_i};
                  nxt_r.vld = 1'b1;
                end
              end
            end
            afd_pkg::AFD_PLAIN: begin
              nxt_r.chr = {9'h000, in_data_i[6:0]};
              nxt_r.vld = 1'b1;
            end
            default: begin
              if (r_ff.count != 8'h00) begin
                nxt_r.chr   = map_code;
                nxt_r.vld   = 1'b1;
                nxt_r.count = r_ff.count - 8'h01;
              end else begin
                nxt_r.st = afd_pkg::AFD_DROP;
              end
            end
          endcase
        end
        afd_pkg::AFD_DROP: begin
          nxt_r.st = afd_pkg::AFD_DROP;
        end
      endcase
      // field end closes the record and marks the last output
      if (in_last_i) begin
        nxt_r.st  = afd_pkg::AFD_FORM;
        nxt_r.fin = 1'b1;
        if (!nxt_r.vld) begin
          nxt_r.chr = `AFD_PAD_WORD;
          nxt_r.vld = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      r_ff <= '{st: afd_pkg::AFD_IDLE, form: afd_pkg::AFD_PLAIN, count: 8'h00,
                base: 16'h0000, hi: 8'h00, have_hi: 1'b0, chr: 16'h0000,
                vld: 1'b0, fin: 1'b0};
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign out_char_o  = r_ff.chr;
  assign out_valid_o = r_ff.vld;
  assign out_end_o   = r_ff.fin;
  assign form_o      = r_ff.form;

  // ************************************************************
  // checks
  // ************************************************************
  AST_RAW_PAIR: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (take && r_ff.st == afd_pkg::AFD_BODY && r_ff.form == afd_pkg::AFD_RAW && r_ff.have_hi
     && {r_ff.hi, in_data_i} != `AFD_PAD_WORD)
    |=> (out_valid_o && out_char_o == {$past(r_ff.hi), $past(in_data_i)}))
    else $error("raw pair not emitted");
  AST_COUNT_LOAD: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (take && r_ff.st == afd_pkg::AFD_COUNT && !in_last_i) |=> r_ff.count == $past(in_data_i))
    else $error("count not loaded");
  AST_HALF_BASE: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (take && r_ff.st == afd_pkg::AFD_BASE_HI && r_ff.form == afd_pkg::AFD_HALF)
    |=> r_ff.base == {1'b0, $past(in_data_i), 7'h00})
    else $error("half page base wrong");
  AST_MAP: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (take && r_ff.st == afd_pkg::AFD_BODY && r_ff.form[1] && r_ff.count != 8'h00
     && in_data_i[7]) |=> out_char_o == $past(r_ff.base) + {9'h000, $past(in_data_i[6:0])})
    else $error("offset char wrong");
  AST_FULL_BASE: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (take && r_ff.st == afd_pkg::AFD_BASE_LO) |=> r_ff.base[7:0] == $past(in_data_i))
    else $error("full base low byte wrong");
  AST_SEVEN_BIT: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (take && r_ff.st == afd_pkg::AFD_BODY && r_ff.form[1] && r_ff.count != 8'h00
     && !in_data_i[7]) |=> out_char_o == {9'h000, $past(in_data_i[6:0])})
    else $error("7-bit char wrong");
  AST_FORM_HOLD: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (r_ff.st != afd_pkg::AFD_IDLE && r_ff.st != afd_pkg::AFD_FORM) |=> $stable(form_o))
    else $error("form changed mid record");
  AST_STOP: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (take && r_ff.st == afd_pkg::AFD_BODY && r_ff.form[1] && r_ff.count == 8'h00
     && !in_last_i) |=> !out_valid_o)
    else $error("char after count");
  AST_FFFF_END: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (take && r_ff.st == afd_pkg::AFD_BODY && r_ff.form == afd_pkg::AFD_RAW && r_ff.have_hi
     && {r_ff.hi, in_data_i} == `AFD_PAD_WORD && !in_last_i) |=> r_ff.st == afd_pkg::AFD_DROP)
    else $error("ffff did not end string");
  AST_HOLD_OUT: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (out_valid_o && !out_ready_i) |=> (out_valid_o && $stable(out_char_o) && $stable(out_end_o)))
    else $error("output dropped under stall");
  COV_RAW: cover property (@(posedge core_clk_i) take && r_ff.st == afd_pkg::AFD_FORM
    && in_data_i == `AFD_TAG_RAW);
  COV_HALF_FF: cover property (@(posedge core_clk_i) take && r_ff.form == afd_pkg::AFD_HALF
    && r_ff.st == afd_pkg::AFD_BODY && r_ff.count != 8'h00 && in_data_i == `AFD_PAD_BYTE);
  COV_FULL: cover property (@(posedge core_clk_i) r_ff.form == afd_pkg::AFD_FULL && out_end_o);
  COV_DROP: cover property (@(posedge core_clk_i) take && r_ff.st == afd_pkg::AFD_DROP
    && !in_last_i);
endmodule // afd_decoder

/* File: bench/afd_src_model.sv */
// byte source standing in for the terminal's record read path
`timescale 1ns/1ps
module afd_src_model (
  input  wire logic       core_clk_i,
  input  wire logic       in_ready_i,
  output logic      [7:0] in_data_o,
  output logic            in_valid_o,
  output logic            in_last_o
);
  logic [8:0] q[$];
  logic       taken;
  initial begin
    in_data_o  = 8'h00;
    in_valid_o = 1'b0;
    in_last_o  = 1'b0;
    taken      = 1'b0;
  end
  // records go out exactly as written, ff padding included
  task automatic push(input logic [7:0] b, input logic l);
    q.push_back({l, b});
  endtask
  always @(posedge core_clk_i) taken <= in_valid_o && in_ready_i;
  // byte held until taken; idle data toggles so a stale value is never trusted
  always @(negedge core_clk_i) begin
    if (taken && q.size() > 0) q.pop_front();
    if (q.size() > 0) begin
      {in_last_o, in_data_o} <= q[0];
      in_valid_o <= 1'b1;
    end else begin
      in_data_o  <= ~in_data_o;
      in_valid_o <= 1'b0;
      in_last_o  <= 1'b0;
    end
  end
endmodule // afd_src_model

/* File: bench/afd_decoder_tb_top.sv */
// testbench for the alpha field decoder
`timescale 1ns/1ps
module afd_decoder_tb_top;
  logic        core_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  in_data_i;
  logic        in_valid_i, in_last_i, in_ready_o, out_valid_o, out_end_o;
  logic        out_ready_i = 1'b1;
  logic [15:0] out_char_o;
  logic [1:0]  form_o;
  logic [16:0] got_q[$];
  logic [1:0]  form_q[$];
  int          fails = 0;
  int          comparisons = 0;
  int          cyc = 0;
  int          held = 0;
  int          ready_bad = 0;
  bit          stall = 1'b0;
  always #2 core_clk_i = ~core_clk_i;
  afd_decoder dut_u (.core_clk_i(core_clk_i), .rst_i(rst_i), .in_data_i(in_data_i),
    .in_valid_i(in_valid_i), .in_last_i(in_last_i), .in_ready_o(in_ready_o),
    .out_char_o(out_char_o), .out_valid_o(out_valid_o), .out_end_o(out_end_o),
    .out_ready_i(out_ready_i), .form_o(form_o));
  afd_src_model src_u (.core_clk_i(core_clk_i), .in_ready_i(in_ready_o),
    .in_data_o(in_data_i), .in_valid_o(in_valid_i), .in_last_o(in_last_i));
  // ****************************************
  // consumer and watchdog
  // ****************************************
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (out_valid_o === 1'b1 && out_ready_i === 1'b1) begin
      got_q.push_back({out_end_o, out_char_o});
      form_q.push_back(form_o);
    end
    // a full, unaccepted output slot must refuse the next byte
    if (out_valid_o === 1'b1 && out_ready_i === 1'b0) begin
      held <= held + 1;
      if (in_ready_o !== 1'b0) begin
        ready_bad <= ready_bad + 1;
      end
    end
    if (cyc == 3000) begin
      fails++;
      wrap_up();
    end
  end
  // stalling the consumer drops out_ready_i two cycles in four; in those cycles the decoder refuses input bytes while its output slot is full
  always @(negedge core_clk_i) out_ready_i <= !(stall && cyc[1]);
  task automatic wrap_up();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [16:0] exp, input logic [16:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic run(input string nm, input logic [7:0] b[$], input logic [16:0] w[$],
                     input logic [1:0] f);
    int n;
    n = 0;
    got_q.delete();
    form_q.delete();
    foreach (b[i]) src_u.push(b[i], i == b.size() - 1);
    while (got_q.size() < w.size() && n < 300) begin
      @(posedge core_clk_i);
      n++;
    end
    repeat (6) @(posedge core_clk_i);
    chk({nm, " words"}, 17'(w.size()), 17'(got_q.size()));
    foreach (w[i]) if (i < got_q.size()) begin
      chk(nm, w[i], got_q[i]);
      chk({nm, " form"}, {15'h0000, f}, {15'h0000, form_q[i]});
    end
    $display("test %s done", nm);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_half();
    stall = 1'b0;
    run("half", '{8'h81, 8'h05, 8'h13, 8'h53, 8'h95, 8'ha6, 8'h41, 8'hff, 8'hff},
        '{17'h00053, 17'h00995, 17'h009a6, 17'h00041, 17'h009ff, 17'h1ffff},
        2'h2);
    run("half short", '{8'h81, 8'h02, 8'h13, 8'hd5, 8'h41, 8'hff, 8'hff},
        '{17'h009d5, 17'h00041, 17'h1ffff}, 2'h2);
  endtask
  task automatic t_full();
    stall = 1'b1;
    run("full", '{8'h82, 8'h05, 8'h05, 8'h30, 8'h2d, 8'h82, 8'hd3, 8'h2d, 8'h31},
        '{17'h0002d, 17'h00532, 17'h00583, 17'h0002d, 17'h10031},
        2'h3);
    chk("full refused", 17'h00000, 17'(ready_bad));
    chk("full stalled", 17'h00001, 17'(held != 0));
    stall = 1'b0;
  endtask
  task automatic t_raw();
    run("raw", '{8'h80, 8'h12, 8'h34, 8'hab, 8'hcd, 8'hff, 8'hff, 8'hff},
        '{17'h01234, 17'h0abcd, 17'h1ffff}, 2'h1);
    run("raw odd", '{8'h80, 8'h00, 8'h41, 8'hff},
        '{17'h00041, 17'h1ffff}, 2'h1);
  endtask
  task automatic t_plain();
    run("plain", '{8'h41, 8'hc2}, '{17'h00041, 17'h10042}, 2'h0);
  endtask
  initial begin
    repeat (5) @(negedge core_clk_i);
    rst_i <= 1'b0;
    @(negedge core_clk_i);
    t_half();
    t_full();
    t_raw();
    t_plain();
    wrap_up();
  end
endmodule // afd_decoder_tb_top
